// ---- rtl/mon_limits_consts.svh ----
// Constants for the monitor limit register bank
`ifndef MON_LIMITS_CONSTS_SVH
`define MON_LIMITS_CONSTS_SVH

`define LIM_COUNT          7

`define CODE_VOUT_UV       8'h43
`define CODE_IOUT_OC       8'h4a
`define CODE_OT_FAULT      8'h4f
`define CODE_OT_WARN       8'h51
`define CODE_VIN_OV        8'h57
`define CODE_VIN_UV        8'h58
`define CODE_PIN_OP        8'h6b

`define MASK_12BIT         16'h0fff
`define MASK_15BIT         16'h7fff

`define RESET_VOUT_UV      16'h0000
`define RESET_IOUT_OC      16'h0fff
`define RESET_OT_FAULT     16'h0fff
`define RESET_OT_WARN      16'h0fff
`define RESET_VIN_OV       16'h0fff
`define RESET_VIN_UV       16'h0000
`define RESET_PIN_OP       16'h7fff

`endif

// ---- rtl/mon_limits_pkg.sv ----
// Types shared by the monitor limit register bank
package mon_limits_pkg;

  typedef enum logic {
    CMP_OVER,
    CMP_UNDER
  } cmp_dir_t;

endpackage

// ---- rtl/limit_compare.sv ----
// One measurement against one limit, registered event pulse
`timescale 1ns/1ps
`include "mon_limits_consts.svh"

module limit_compare #(
  parameter int                       W   = 16,
  parameter mon_limits_pkg::cmp_dir_t DIR = mon_limits_pkg::CMP_OVER
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Measurement and limit
  input  wire logic [W-1:0] meas,
  input  wire logic         meas_valid,
  input  wire logic [W-1:0] threshold,
  // Event
  output logic              crossed
);
  import mon_limits_pkg::*;

  logic next_crossed;

  // Raw compare, no scaling: both sides share one coding
  always_comb
  begin
    next_crossed = 1'b0;
    if (meas_valid)
    begin
      if (DIR == CMP_OVER)
        next_crossed = (meas > threshold);
      else
        next_crossed = (meas < threshold);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      crossed <= 1'b0;
    else
      crossed <= next_crossed;
  end

  a_cross_trips: assert property (@(posedge clk) disable iff (rst)
    meas_valid && ((DIR == CMP_OVER) ? (meas > threshold) : (meas < threshold)) |=> crossed)
    else $error("limit crossing not flagged");

  a_cross_quiet: assert property (@(posedge clk) disable iff (rst)
    !meas_valid |=> !crossed)
    else $error("event without a new measurement");

endmodule

// ---- rtl/monitor_limit_registers.sv ----
// Limit register bank with per-limit crossing detectors
`timescale 1ns/1ps
`include "mon_limits_consts.svh"

module monitor_limit_registers (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Command port from the bus protocol engine
  input  wire logic [7:0]  cmd_code,
  input  wire logic        cmd_write,
  input  wire logic        cmd_read,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  output logic             cmd_unsupported,
  // Measurements from the conversion path
  input  wire logic [11:0] vout_meas,
  input  wire logic        vout_valid,
  input  wire logic [11:0] iout_meas,
  input  wire logic        iout_valid,
  input  wire logic [11:0] temp_meas,
  input  wire logic        temp_valid,
  input  wire logic [11:0] vin_meas,
  input  wire logic        vin_valid,
  input  wire logic [14:0] pin_meas,
  input  wire logic        pin_valid,
  // Crossing events to the status logic
  output logic             vout_uv_warn,
  output logic             iout_oc_warn,
  output logic             ot_fault,
  output logic             ot_warn,
  output logic             vin_ov_warn,
  output logic             vin_uv_warn,
  output logic             pin_op_warn
);
  import mon_limits_pkg::*;

  localparam int N = `LIM_COUNT;

  // Entry order: vout_uv, iout_oc, ot_fault, ot_warn, vin_ov, vin_uv, pin_op
  localparam logic [7:0] CODE [N] = '{`CODE_VOUT_UV, `CODE_IOUT_OC, `CODE_OT_FAULT,
    `CODE_OT_WARN, `CODE_VIN_OV, `CODE_VIN_UV, `CODE_PIN_OP};
  localparam logic [15:0] MASK [N] = '{`MASK_12BIT, `MASK_12BIT, `MASK_12BIT,
    `MASK_12BIT, `MASK_12BIT, `MASK_12BIT, `MASK_15BIT};
  localparam logic [15:0] RSTV [N] = '{`RESET_VOUT_UV, `RESET_IOUT_OC, `RESET_OT_FAULT,
    `RESET_OT_WARN, `RESET_VIN_OV, `RESET_VIN_UV, `RESET_PIN_OP};
  localparam cmp_dir_t DIRS [N] = '{CMP_UNDER, CMP_OVER, CMP_OVER, CMP_OVER,
    CMP_OVER, CMP_UNDER, CMP_OVER};

  logic [15:0] thr      [N];
  logic [15:0] next_thr [N];
  logic [15:0] meas_w   [N];
  logic        meas_v   [N];
  logic        evt      [N];

  logic [15:0] next_rd_data;
  logic        next_rd_valid;
  logic        next_cmd_unsupported;
  logic        first_cycle;

  // Widen every measurement to the register word
  assign meas_w[0] = {4'h0, vout_meas};
  assign meas_w[1] = {4'h0, iout_meas};
  assign meas_w[2] = {4'h0, temp_meas};
  assign meas_w[3] = {4'h0, temp_meas};
  assign meas_w[4] = {4'h0, vin_meas};
  assign meas_w[5] = {4'h0, vin_meas};
  assign meas_w[6] = {1'b0, pin_meas};
  assign meas_v[0] = vout_valid;
  assign meas_v[1] = iout_valid;
  assign meas_v[2] = temp_valid;
  assign meas_v[3] = temp_valid;
  assign meas_v[4] = vin_valid;
  assign meas_v[5] = vin_valid;
  assign meas_v[6] = pin_valid;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_lim
      // Reserved bits are never stored, so a read can't leak them
      always_comb
      begin
        next_thr[g] = thr[g];
        if (cmd_write && (cmd_code == CODE[g]))
          next_thr[g] = cmd_wdata & MASK[g];
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          thr[g] <= RSTV[g];
        else
          thr[g] <= next_thr[g];
      end

      limit_compare #(
        .W   (16),
        .DIR (DIRS[g])
      ) u_cmp (
        .clk        (clk),
        .rst        (rst),
        .meas       (meas_w[g]),
        .meas_valid (meas_v[g]),
        .threshold  (thr[g]),
        .crossed    (evt[g])
      );

      a_write_store: assert property (@(posedge clk) disable iff (rst)
        cmd_write && (cmd_code == CODE[g]) |=> thr[g] == ($past(cmd_wdata) & MASK[g]))
        else $error("limit write not stored masked");

      a_limit_hold: assert property (@(posedge clk) disable iff (rst)
        !(cmd_write && (cmd_code == CODE[g])) |=> $stable(thr[g]))
        else $error("limit changed without a write");

      a_read_entry: assert property (@(posedge clk) disable iff (rst)
        cmd_read && (cmd_code == CODE[g]) |=> rd_valid && (rd_data == $past(thr[g])))
        else $error("read did not return the stored limit");
    end
  endgenerate

  assign vout_uv_warn = evt[0];
  assign iout_oc_warn = evt[1];
  assign ot_fault     = evt[2];
  assign ot_warn      = evt[3];
  assign vin_ov_warn  = evt[4];
  assign vin_uv_warn  = evt[5];
  assign pin_op_warn  = evt[6];

  // Read mux and unknown-code flag; a write to an unknown code is dropped
  always_comb
  begin
    next_rd_data         = 16'h0000;
    next_rd_valid        = cmd_read;
    next_cmd_unsupported = cmd_read | cmd_write;
    for (int i = 0; i < N; i++)
    begin
      if (cmd_code == CODE[i])
      begin
        next_cmd_unsupported = 1'b0;
        if (cmd_read)
          next_rd_data = thr[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data         <= 16'h0000;
      rd_valid        <= 1'b0;
      cmd_unsupported <= 1'b0;
      first_cycle     <= 1'b1;
    end
    else
    begin
      rd_data         <= next_rd_data;
      rd_valid        <= next_rd_valid;
      cmd_unsupported <= next_cmd_unsupported;
      first_cycle     <= 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_write_vout_uv;
    cmd_write && !cmd_read && (cmd_code == `CODE_VOUT_UV);
  endsequence

  sequence s_read_vout_uv;
    cmd_read && !cmd_write && (cmd_code == `CODE_VOUT_UV);
  endsequence

  a_reset_low_limits: assert property (
    first_cycle |-> (thr[0] == `RESET_VOUT_UV) && (thr[5] == `RESET_VIN_UV))
    else $error("under limits not at reset value");

  a_reset_iout_limit: assert property (
    first_cycle |-> thr[1] == `RESET_IOUT_OC)
    else $error("overcurrent limit not at reset value");

  a_reset_temp_limits: assert property (
    first_cycle |-> (thr[2] == `RESET_OT_FAULT) && (thr[3] == `RESET_OT_WARN))
    else $error("temperature limits not at reset value");

  a_reset_vin_ov: assert property (
    first_cycle |-> (thr[4] == `RESET_VIN_OV) && (thr[6] == `RESET_PIN_OP))
    else $error("input limits not at reset value");

  a_write_readback: assert property (
    s_write_vout_uv ##1 s_read_vout_uv |=>
      rd_valid && (rd_data == ($past(cmd_wdata, 2) & `MASK_12BIT)))
    else $error("written limit not read back masked");

  a_upper_zero: assert property (
    rd_valid && ($past(cmd_code) != `CODE_PIN_OP) |-> rd_data[15:12] == 4'h0)
    else $error("reserved upper bits read nonzero");

  a_power_bit15: assert property (
    rd_valid |-> !rd_data[15])
    else $error("power limit bit 15 read nonzero");

  a_read_latency: assert property (
    cmd_read |=> rd_valid ##1 (!rd_valid || $past(cmd_read)))
    else $error("read answer not one cycle later");

  a_rd_idle_zero: assert property (
    !rd_valid |-> rd_data == 16'h0000)
    else $error("read word not zero outside an answer");

  a_unknown_code: assert property (
    (cmd_read || cmd_write) &&
      !(cmd_code inside {`CODE_VOUT_UV, `CODE_IOUT_OC, `CODE_OT_FAULT, `CODE_OT_WARN,
      `CODE_VIN_OV, `CODE_VIN_UV, `CODE_PIN_OP}) |=> cmd_unsupported && (rd_data == 16'h0000))
    else $error("unknown code not flagged");

endmodule

// ---- tb/mon_host_model.sv ----
// Host-side command driver model for the limit register bank
`timescale 1ns/1ps

module mon_host_model (
  // Clock
  input  wire logic        clk,
  // Command port
  output logic      [7:0]  cmd_code,
  output logic             cmd_write,
  output logic             cmd_read,
  output logic      [15:0] cmd_wdata,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid
);
  initial
  begin
    cmd_code  = 8'h00;
    cmd_write = 1'b0;
    cmd_read  = 1'b0;
    cmd_wdata = 16'h0000;
  end

  // Limits arrive already in direct format; idle lines show inverted values
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk) #1;
    cmd_code  = c;
    cmd_wdata = d;
    cmd_write = 1'b1;
    @(posedge clk) #1;
    cmd_write = 1'b0;
    cmd_code  = ~c;
    cmd_wdata = ~d;
  endtask

  // Write, then read the same code on the very next cycle with no idle gap
  task automatic wr_rd(input logic [7:0] c, input logic [15:0] w, output logic [15:0] d,
                       output logic v);
    @(posedge clk) #1;
    cmd_code  = c;
    cmd_wdata = w;
    cmd_write = 1'b1;
    @(posedge clk) #1;
    cmd_write = 1'b0;
    cmd_read  = 1'b1;
    @(posedge clk) #1;
    d         = rd_data;
    v         = rd_valid;
    cmd_read  = 1'b0;
    cmd_code  = ~c;
    cmd_wdata = ~w;
  endtask

  // Answer stands one cycle, so it is taken just after the accepting edge
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
    @(posedge clk) #1;
    cmd_code = c;
    cmd_read = 1'b1;
    @(posedge clk) #1;
    d        = rd_data;
    v        = rd_valid;
    cmd_read = 1'b0;
    cmd_code = ~c;
  endtask
endmodule

// ---- tb/monitor_limit_registers_tb_top.sv ----
// Self-checking bench for the limit register bank
`timescale 1ns/1ps
`include "mon_limits_consts.svh"

module monitor_limit_registers_tb_top;
  localparam logic [7:0]  CODES [7] = '{`CODE_VOUT_UV, `CODE_IOUT_OC, `CODE_OT_FAULT,
    `CODE_OT_WARN, `CODE_VIN_OV, `CODE_VIN_UV, `CODE_PIN_OP};
  localparam logic [15:0] RSTV [7] = '{`RESET_VOUT_UV, `RESET_IOUT_OC, `RESET_OT_FAULT,
    `RESET_OT_WARN, `RESET_VIN_OV, `RESET_VIN_UV, `RESET_PIN_OP};
  localparam int          SRC [7]   = '{0, 1, 2, 2, 3, 3, 4};
  localparam logic [6:0]  OVER      = 7'b1011110;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  cmd_code;
  logic        cmd_write;
  logic        cmd_read;
  logic [15:0] cmd_wdata;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        cmd_unsupported;
  logic [14:0] mv [5] = '{15'h0, 15'h0, 15'h0, 15'h0, 15'h0};
  logic [4:0]  vld = 5'h00;
  logic [6:0]  evt;
  logic [15:0] lim [7];
  int          failures = 0;
  int          total_checks = 0;

  always #5 clk = ~clk;

  mon_host_model i_mon_host_model (
    .clk(clk), .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_read(cmd_read),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));

  monitor_limit_registers i_monitor_limit_registers (
    .clk(clk), .rst(rst), .cmd_code(cmd_code), .cmd_write(cmd_write),
    .cmd_read(cmd_read), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
    .cmd_unsupported(cmd_unsupported),
    .vout_meas(mv[0][11:0]), .vout_valid(vld[0]), .iout_meas(mv[1][11:0]),
    .iout_valid(vld[1]), .temp_meas(mv[2][11:0]), .temp_valid(vld[2]),
    .vin_meas(mv[3][11:0]), .vin_valid(vld[3]), .pin_meas(mv[4]), .pin_valid(vld[4]),
    .vout_uv_warn(evt[0]), .iout_oc_warn(evt[1]), .ot_fault(evt[2]), .ot_warn(evt[3]),
    .vin_ov_warn(evt[4]), .vin_uv_warn(evt[5]), .pin_op_warn(evt[6]));

  function automatic logic [15:0] mask_of(input int i);
    return (i == 6) ? `MASK_15BIT : `MASK_12BIT;
  endfunction

  function automatic logic [6:0] expect_evt(input int s, input logic [14:0] m);
    logic [6:0] e;
    for (int i = 0; i < 7; i++)
      e[i] = (SRC[i] == s) && (OVER[i] ? ({1'b0, m} > lim[i]) : ({1'b0, m} < lim[i]));
    return e;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Equal values sit on the boundary and must stay quiet
  task automatic meas(input int s, input logic [14:0] m);
    logic [6:0] e;
    e = expect_evt(s, m);
    @(posedge clk) #1;
    mv[s]  = m;
    vld[s] = 1'b1;
    @(posedge clk) #1;
    vld[s] = 1'b0;
    mv[s]  = ~m;
    check({9'h0, evt}, {9'h0, e});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    failures++;
    tally_and_finish();
  end

  initial
  begin
    logic [15:0] d;
    logic        v;
    logic [15:0] w;
    void'($urandom(32'hdd84919d));
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      i_mon_host_model.rd(CODES[i], d, v);
      check(d, RSTV[i]);
      check({15'h0, v}, 16'h0001);
    end
    // Upper bits forced high so dropped reserved bits actually show
    for (int i = 0; i < 7; i++)
    begin
      w = (i == 0) ? 16'hffff : (16'($urandom) | 16'hf000);
      i_mon_host_model.wr(CODES[i], w);
      lim[i] = w & mask_of(i);
    end
    i_mon_host_model.wr(8'h42, 16'h0123);
    check({15'h0, cmd_unsupported}, 16'h0001);
    i_mon_host_model.rd(8'h42, d, v);
    check({15'h0, cmd_unsupported}, 16'h0001);
    check(d, 16'h0000);
    check({15'h0, v}, 16'h0001);
    for (int i = 0; i < 7; i++)
    begin
      i_mon_host_model.rd(CODES[i], d, v);
      check(d, lim[i]);
    end
    // Read issued the cycle after the write must already see the new limit
    w = 16'($urandom) | 16'hf000;
    i_mon_host_model.wr_rd(CODES[0], w, d, v);
    lim[0] = w & mask_of(0);
    check(d, lim[0]);
    check({15'h0, v}, 16'h0001);
    for (int i = 0; i < 7; i++)
    begin
      w = 16'($urandom_range(1, int'(mask_of(i)) - 1));
      i_mon_host_model.wr(CODES[i], w);
      lim[i] = w;
      for (int k = -1; k < 2; k++)
        meas(SRC[i], 15'(int'(w) + k));
    end
    tally_and_finish();
  end
endmodule
